// File: design/output_macrocell_regs.vh
/*
  constants shared by the output macrocell array: register offsets, field
  positions, reset values and the product-term allocation per cell.
  assumes it is included by bare name from the design files and the bench monitor.

*/
`ifndef OUTPUT_MACROCELL_REGS_VH
`define OUTPUT_MACROCELL_REGS_VH

// geometry
`define CELL_COUNT 10
`define TERM_TOTAL 120
`define TERMS_PAIR0 8
`define TERMS_PAIR1 10
`define TERMS_PAIR2 12
`define TERMS_PAIR3 14
`define TERMS_PAIR4 16

// register offsets (byte addresses, one word each)
`define OFS_STATUS_Q 8'h00
`define OFS_STATUS_PIN 8'h04
`define OFS_STATUS_SUM 8'h08
`define OFS_STATUS_OE 8'h0c
`define OFS_MODE_VIEW 8'h10
`define OFS_POL_VIEW 8'h14
`define OFS_CELL_CFG_BASE 8'h20
`define OFS_CELL_CFG_LAST 8'h44

// per-cell config word fields
`define CFG_MODE_BIT 0
`define CFG_POL_BIT 1
`define CFG_OE_LSB 2
`define CFG_OE_MSB 3
`define CFG_WIDTH 4
`define CFG_RESET 4'h0

// combinatorial enable select encodings
`define OE_SEL_TERM 2'h0
`define OE_SEL_ON 2'h1
`define OE_SEL_OFF 2'h2

`endif

// File: design/bit_sync2.v
/*
  two-flop synchroniser for a group of independent levels.
  assumes each bit is a slow level; no multi-bit coherence is promised.
*/
`timescale 1ns/1ps
`default_nettype none

module bit_sync2 #(
  parameter WIDTH = 1
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_ff; // first stage, read only by stage two
  reg [WIDTH-1:0] sync_ff; // second stage, safe for logic

  // plain two-stage chain, both cleared to zero
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // bit_sync2

`default_nettype wire

// File: design/macrocell_core.v
/*
  one macrocell: sum gate over its product terms and the D flip-flop.
  assumes terms, clear and set come from logic on i_mclk; clear is used
  as an asynchronous clear, so it must be glitch free.
*/
`timescale 1ns/1ps
`default_nettype none

module macrocell_core #(
  parameter NTERMS = 8
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire [NTERMS-1:0] i_terms,
  input wire i_async_clear_term,
  input wire i_sync_set_term,
  output wire o_sum,
  output wire o_nxt_q,
  output wire o_q
);

  reg q_ff; // the cell's D flip-flop
  wire sum; // or of all logic terms

  assign sum = |i_terms;
  // set overrides the sum term at the next edge
  assign o_nxt_q = i_sync_set_term ? 1'b1 : sum;

  // clear acts with no clock and beats set
  always @(posedge i_mclk or negedge i_nrst or posedge i_async_clear_term) begin
    if (!i_nrst) begin
      q_ff <= 1'b0;
    end else if (i_async_clear_term) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= o_nxt_q;
    end
  end

  assign o_sum = sum;
  assign o_q = q_ff;

endmodule // macrocell_core

`default_nettype wire

// File: design/output_macrocell.v
/*
  ten output macrocells with configuration registers on a plain port.
  assumes the product terms, enable terms, clear and set arrive from an
  and array clocked by i_mclk; pin inputs are asynchronous and are
  synchronised here. read data appear the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "output_macrocell_regs.vh"

module output_macrocell (
  input wire i_mclk,
  input wire i_nrst,
  // and array side
  input wire [`TERM_TOTAL-1:0] i_terms,
  input wire [`CELL_COUNT-1:0] i_oe_terms,
  input wire i_async_clear_term,
  input wire i_sync_set_term,
  // feedback into the and array
  output wire [`CELL_COUNT-1:0] o_fb_true,
  output wire [`CELL_COUNT-1:0] o_fb_inv,
  // the ten pins as three signals each
  input wire [`CELL_COUNT-1:0] i_pin,
  output wire [`CELL_COUNT-1:0] o_pin,
  output wire [`CELL_COUNT-1:0] o_pin_oe,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [31:0] o_rdata
);

  // term count of cell i; pairs mirror around the middle
  function integer terms_of;
    input integer idx;
    integer pair;
    begin
      pair = (idx < 5) ? idx : (9 - idx);
      case (pair)
        0: terms_of = `TERMS_PAIR0;
        1: terms_of = `TERMS_PAIR1;
        2: terms_of = `TERMS_PAIR2;
        3: terms_of = `TERMS_PAIR3;
        default: terms_of = `TERMS_PAIR4;
      endcase
    end
  endfunction

  // first term index of cell i in the flat term bus
  function integer base_of;
    input integer idx;
    integer k;
    begin
      base_of = 0;
      for (k = 0; k < 10; k = k + 1) begin
        if (k < idx) begin
          base_of = base_of + terms_of(k);
        end
      end
    end
  endfunction

  // configuration: one 4-bit word per cell
  reg [`CFG_WIDTH*`CELL_COUNT-1:0] cfg_ff; // flat cell configs
  reg [31:0] rdata_ff; // read data, valid the cycle after i_rd

  // per-cell outputs and views
  reg [`CELL_COUNT-1:0] pin_ff; // pin level driven out
  reg [`CELL_COUNT-1:0] oe_ff; // pin drive enable
  reg [`CELL_COUNT-1:0] fb_true_ff; // feedback, true form
  reg [`CELL_COUNT-1:0] fb_inv_ff; // feedback, complement form
  wire [`CELL_COUNT-1:0] sum; // sum gate of each cell
  wire [`CELL_COUNT-1:0] nxt_q; // d input of each cell
  wire [`CELL_COUNT-1:0] q; // flip-flop state of each cell
  wire [`CELL_COUNT-1:0] pin_sync; // pin level after two flops
  wire [`CELL_COUNT-1:0] mode_reg; // 1 = registered
  wire [`CELL_COUNT-1:0] pol_inv; // 1 = inverted pin

  // register decode
  wire cfg_hit; // address inside the cell config window
  wire [7:0] cfg_ofs; // byte offset within the window
  wire [3:0] cfg_idx; // cell number addressed
  reg [31:0] nxt_rdata; // read mux result

  // pins come from outside the clock domain
  bit_sync2 #(
    .WIDTH(`CELL_COUNT)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_async(i_pin),
    .o_sync(pin_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CELL_COUNT; gi = gi + 1) begin : g_cell
      // this cell's config fields
      wire cell_reg; // registered mode selected
      wire cell_inv; // inverted polarity selected
      wire [1:0] cell_oe_sel; // combinatorial enable setting
      reg nxt_pin; // next pin level
      reg nxt_oe; // next enable
      reg nxt_fb; // next feedback, true form

      assign cell_reg = cfg_ff[gi*`CFG_WIDTH+`CFG_MODE_BIT];
      assign cell_inv = cfg_ff[gi*`CFG_WIDTH+`CFG_POL_BIT];
      assign cell_oe_sel = cfg_ff[gi*`CFG_WIDTH+`CFG_OE_MSB:gi*`CFG_WIDTH+`CFG_OE_LSB];
      assign mode_reg[gi] = cell_reg;
      assign pol_inv[gi] = cell_inv;

      // sum gate and flop, sized to this cell's share of terms
      macrocell_core #(
        .NTERMS(terms_of(gi))
      ) u_core (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_terms(i_terms[base_of(gi)+terms_of(gi)-1:base_of(gi)]),
        .i_async_clear_term(i_async_clear_term),
        .i_sync_set_term(i_sync_set_term),
        .o_sum(sum[gi]),
        .o_nxt_q(nxt_q[gi]),
        .o_q(q[gi])
      );

      // next pin, enable and feedback for this cell
      always @* begin
        nxt_pin = 1'b0;
        nxt_oe = 1'b0;
        nxt_fb = 1'b0;
        if (cell_reg) begin
          // clear held over the edge keeps q at zero
          nxt_pin = (i_async_clear_term ? 1'b0 : nxt_q[gi]) ^ cell_inv;
          nxt_oe = i_oe_terms[gi];
          // feedback is /q, never the pin
          nxt_fb = ~(i_async_clear_term ? 1'b0 : nxt_q[gi]);
        end else begin
          nxt_pin = sum[gi] ^ cell_inv;
          case (cell_oe_sel)
            `OE_SEL_ON: nxt_oe = 1'b1;
            `OE_SEL_OFF: nxt_oe = 1'b0;
            default: nxt_oe = i_oe_terms[gi];
          endcase
          // pin side of the buffer, so an external drive shows here
          nxt_fb = pin_sync[gi];
        end
      end

      // output flops; in registered mode pin and feedback follow q on the same edge
      always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          pin_ff[gi] <= 1'b0;
          oe_ff[gi] <= 1'b0; // pins float after reset
          fb_true_ff[gi] <= 1'b1;
          fb_inv_ff[gi] <= 1'b0;
        end else begin
          pin_ff[gi] <= nxt_pin;
          oe_ff[gi] <= nxt_oe;
          fb_true_ff[gi] <= nxt_fb;
          fb_inv_ff[gi] <= ~nxt_fb;
        end
      end
    end
  endgenerate

  // config window decode; one aligned word per cell
  assign cfg_hit = (i_addr >= `OFS_CELL_CFG_BASE) && (i_addr <= `OFS_CELL_CFG_LAST)
                   && (i_addr[1:0] == 2'h0);
  assign cfg_ofs = i_addr - `OFS_CELL_CFG_BASE;
  assign cfg_idx = cfg_ofs[5:2];

  // config writes; a change takes effect on the next edge
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_ff <= {`CELL_COUNT{`CFG_RESET}};
    end else if (i_wr && cfg_hit) begin
      cfg_ff[cfg_idx*`CFG_WIDTH +: `CFG_WIDTH] <= i_wdata[`CFG_WIDTH-1:0];
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (i_addr)
      `OFS_STATUS_Q: nxt_rdata[`CELL_COUNT-1:0] = q;
      `OFS_STATUS_PIN: nxt_rdata[`CELL_COUNT-1:0] = pin_sync;
      `OFS_STATUS_SUM: nxt_rdata[`CELL_COUNT-1:0] = sum;
      `OFS_STATUS_OE: nxt_rdata[`CELL_COUNT-1:0] = oe_ff;
      `OFS_MODE_VIEW: nxt_rdata[`CELL_COUNT-1:0] = mode_reg;
      `OFS_POL_VIEW: nxt_rdata[`CELL_COUNT-1:0] = pol_inv;
      default: begin
        if (cfg_hit) begin
          nxt_rdata[`CFG_WIDTH-1:0] = cfg_ff[cfg_idx*`CFG_WIDTH +: `CFG_WIDTH];
        end
      end
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign o_pin = pin_ff;
  assign o_pin_oe = oe_ff;
  assign o_fb_true = fb_true_ff;
  assign o_fb_inv = fb_inv_ff;
  assign o_rdata = rdata_ff;

endmodule // output_macrocell

`default_nettype wire

// File: tb/macrocell_monitor.sv
/* port checker for the output macrocell array.
   assumes it is bound to output_macrocell and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "output_macrocell_regs.vh"
module macrocell_monitor (
  input wire i_mclk,
  input wire i_nrst,
  input wire [9:0] i_oe_terms,
  input wire i_async_clear_term,
  input wire i_sync_set_term,
  input wire [9:0] o_fb_true,
  input wire [9:0] o_fb_inv,
  input wire [9:0] o_pin,
  input wire [9:0] o_pin_oe,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr
);
  reg [9:0] mode_ff, pol_ff, on_ff, off_ff; // shadow of the cell config
  reg quiet_ff; // no reset and no write at the last edge
  wire [7:0] ofs = i_addr - `OFS_CELL_CFG_BASE; // offset into the cfg block
  wire [3:0] cel = ofs[5:2]; // cell written
  wire hit = i_wr && i_addr >= `OFS_CELL_CFG_BASE && i_addr <= `OFS_CELL_CFG_LAST
    && ofs[1:0] == 2'h0;
  // snoop cfg writes; a write shows at the pins one edge late, so skip that edge
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      {mode_ff, pol_ff, on_ff, off_ff} <= 40'h0;
      quiet_ff <= 1'b0;
    end else begin
      quiet_ff <= !i_wr;
      if (hit) begin
        mode_ff[cel] <= i_wdata[`CFG_MODE_BIT];
        pol_ff[cel] <= i_wdata[`CFG_POL_BIT];
        on_ff[cel] <= i_wdata[3:2] == `OE_SEL_ON;
        off_ff[cel] <= i_wdata[3:2] == `OE_SEL_OFF;
      end
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_fb_forms_pair: assert property (
    o_fb_inv == ~o_fb_true) else $error("feedback forms not complementary");
  a_clear_pin_level: assert property (
    quiet_ff && $past(i_async_clear_term) |-> ((o_pin ^ pol_ff) & mode_ff) == 10'h0)
    else $error("cleared register not seen at pin");
  a_set_pin_level: assert property (
    quiet_ff && $past(i_sync_set_term) && !$past(i_async_clear_term)
    |-> ((o_pin ^ pol_ff) & mode_ff) == mode_ff) else $error("set register not seen at pin");
  a_reg_oe_term: assert property (
    quiet_ff |-> (o_pin_oe & mode_ff) == ($past(i_oe_terms) & mode_ff))
    else $error("registered enable not its term");
  a_comb_oe_on: assert property (
    quiet_ff |-> (o_pin_oe & ~mode_ff & on_ff) == (~mode_ff & on_ff))
    else $error("dedicated output not driving");
  a_comb_oe_off: assert property (
    quiet_ff |-> (o_pin_oe & ~mode_ff & off_ff) == 10'h0) else $error("dedicated input driving");
  a_comb_oe_term: assert property (
    quiet_ff |-> ((o_pin_oe ^ $past(i_oe_terms)) & ~(mode_ff | on_ff | off_ff)) == 10'h0)
    else $error("dynamic enable not its term");
  a_reg_fb_state: assert property (
    quiet_ff |-> ((o_fb_true ^ o_pin ^ ~pol_ff) & mode_ff) == 10'h0)
    else $error("registered feedback not inverted q");
  c_clear_with_set: cover property (i_async_clear_term && i_sync_set_term);
  c_inverted_reg: cover property (|(mode_ff & pol_ff));
  c_dedicated_out: cover property (|(o_pin_oe & ~mode_ff & on_ff));
endmodule // macrocell_monitor
bind output_macrocell macrocell_monitor u_mon (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_oe_terms(i_oe_terms), .i_async_clear_term(i_async_clear_term),
  .i_sync_set_term(i_sync_set_term), .o_fb_true(o_fb_true), .o_fb_inv(o_fb_inv),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr));
`default_nettype wire

// File: tb/pin_partner.sv
/* board side of the ten pins.
   assumes the bench commands which pins it drives and to what level. */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic [9:0] pin_out,
  input wire logic [9:0] pin_oe,
  input wire logic [9:0] ext_en,
  input wire logic [9:0] ext_val,
  output wire logic [9:0] pin_level
);
  // the device wins where it drives; a pin nobody drives rests on its pull-up
  assign pin_level = (pin_out & pin_oe) | (ext_val & ext_en & ~pin_oe) | (~ext_en & ~pin_oe);
endmodule // pin_partner
`default_nettype wire

// File: tb/testbench.sv
/* self-checking bench for the output macrocell array.
   assumes the monitor is bound in and the pin partner stands for the board. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  logic i_mclk, i_nrst, i_wr, i_rd, i_async_clear_term, i_sync_set_term; // drives
  logic [119:0] i_terms; // product terms of all cells
  logic [9:0] i_oe_terms, ext_en, ext_val; // enable terms, board commands
  logic [7:0] i_addr; // register address
  logic [31:0] i_wdata, rdat; // write data, last read
  wire [9:0] i_pin, o_pin, o_pin_oe, o_fb_true, o_fb_inv; // pin and feedback
  wire [31:0] o_rdata; // read data
  int err_total = 0, compares = 0, cycles = 0; // tallies
  output_macrocell uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_terms(i_terms),
    .i_oe_terms(i_oe_terms), .i_async_clear_term(i_async_clear_term),
    .i_sync_set_term(i_sync_set_term), .o_fb_true(o_fb_true), .o_fb_inv(o_fb_inv),
    .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  pin_partner board (.pin_out(o_pin), .pin_oe(o_pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(i_pin));
  // free-running clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // a hang counts as a mismatch
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  task print_verdict;
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge i_mclk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge i_mclk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic cfg_all(input [9:0] m, input [9:0] p, input [1:0] s);
    for (int c = 0; c < 10; c++) wr(8'(8'h20 + 4 * c), {28'h0, s, p[c], m[c]});
  endtask
  task t_regs;
    for (int c = 0; c < 10; c++) begin
      rd(8'(8'h20 + 4 * c), rdat);
      `CHK("cfg reset", 32'h0, rdat)
    end
    wr(8'h2c, 32'hd);
    rd(8'h2c, rdat);
    `CHK("cfg rw", 32'hd, rdat)
    rd(8'h10, rdat);
    `CHK("mode view", 32'h8, rdat)
    rd(8'hfc, rdat);
    `CHK("unmapped", 32'h0, rdat)
    wr(8'h2c, 32'h0);
  endtask
  // top term of each slice lights only its own cell
  task t_alloc;
    int b;
    int n;
    b = 0;
    for (int c = 0; c < 10; c++) begin
      n = (c < 5) ? 8 + 2 * c : 26 - 2 * c;
      @(posedge i_mclk);
      i_terms <= 120'h1 << (b + n - 1);
      @(posedge i_mclk);
      #1 `CHK("comb pin", 10'h1 << c, o_pin)
      b = b + n;
    end
    cfg_all(10'h0, 10'h3ff, 2'h0);
    @(posedge i_mclk);
    i_terms <= 120'h0;
    @(posedge i_mclk);
    #1 `CHK("inverted pin", 10'h3ff, o_pin)
  endtask
  task t_clear_set;
    cfg_all(10'h3ff, 10'h155, 2'h0);
    rd(8'h14, rdat);
    `CHK("pol view", 32'h155, rdat)
    @(posedge i_mclk);
    i_sync_set_term <= 1'b1;
    @(posedge i_mclk);
    #1 `CHK("set pin", 10'h2aa, o_pin)
    `CHK("set fb", 10'h0, o_fb_true)
    // set stays high; q reads zero in the clear's own cycle only if clear is async
    @(posedge i_mclk);
    {i_async_clear_term, i_rd, i_addr} <= {2'h3, 8'h00};
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 `CHK("cleared q", 32'h0, o_rdata)
    `CHK("clear pin", 10'h155, o_pin)
    `CHK("clear fb", 10'h3ff, o_fb_true)
    @(posedge i_mclk);
    {i_async_clear_term, i_sync_set_term} <= 2'h0;
  endtask
  // cells 0-3 registered, 4 on, 5 off, 6-9 dynamic
  task t_oe_fb;
    cfg_all(10'h00f, 10'h0, 2'h0);
    wr(8'h30, 32'h4);
    wr(8'h34, 32'h8);
    @(posedge i_mclk);
    {i_oe_terms, ext_val} <= {10'h2aa, 10'h020};
    repeat (3) @(posedge i_mclk);
    #1 `CHK("enables", 10'h29a, o_pin_oe)
    `CHK("pin feedback", 10'h021, o_fb_true & 10'h021)
    @(posedge i_mclk);
    // board now drives pin 5 low; pin 0 is low too, yet its feedback must still be /q
    ext_val <= 10'h000;
    repeat (3) @(posedge i_mclk);
    #1 `CHK("reg feedback", 10'h001, o_fb_true & 10'h021)
    `CHK("fb inverse", 10'h020, o_fb_inv & 10'h021)
    rd(8'h0c, rdat);
    `CHK("oe view", 32'h29a, rdat)
  endtask
  initial begin
    {i_nrst, i_wr, i_rd, i_async_clear_term, i_sync_set_term} = 5'h0;
    {i_terms, i_oe_terms, ext_val, i_addr, i_wdata} = 180'h0;
    ext_en = 10'h3ff;
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_regs();
    t_alloc();
    t_clear_set();
    t_oe_fb();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
